/* File: design/eeprom_setup_loader.sv */
/*
  setup loader: uploads the scratch-pad instruction sequence into the
  byte store and downloads stored setups into the register map under a
  condition. assumes the register map answers a read one cycle after
  reg_rd_o with reg_rdata_i and takes writes on reg_wr_o.
*/
// How it works
// RQ1: bytes B1..CF tag conditions 1..31
// RQ2: later setups start with B0, new tag
// RQ3: setups end FE, last FF; FF stops
// RQ4: upload start copies scratch pad, appending
// RQ5: download start uses five-bit condition field
// RQ6: power-up runs download under pin condition
// RQ7: store holds 2048 bytes, pointer spans all
// RQ8: non-data instructions take one byte
// RQ9: data instruction stores N plus four bytes
// RQ10: opcode is count minus one, address hi-lo
// RQ11: byte 0x80 issues an io update
// RQ12: sequence enables pin, updates, then functions
// RQ13: pin functions unarmed emit one sync pulse
// RQ14: writing 0x01 to 0x0005 issues io update
// RQ15: pin-sync sequence inserts steps at 0x0E17
// RQ16: skip until matching tag; conditions always run
// RQ17: nonzero field wins, else latched pin condition
// RQ18: B0 clears the whole tag board
// RQ19: operations exclusive; busy clears when done
`timescale 1ns/1ps
`default_nettype none

module eeprom_setup_loader
  import eeprom_setup_pkg::*;
#(
  parameter int EE_BYTES = EE_BYTES_DEFAULT
) (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic        upload_start_i,
  input  wire logic        download_start_i,
  input  wire logic [4:0]  condition_i,
  input  wire logic [1:0]  config_select_pin_lo_i,
  input  wire logic [1:0]  config_select_pin_hi_i,
  input  wire logic [7:0]  reg_rdata_i,
  output var  logic        reg_rd_o,
  output var  logic        reg_wr_o,
  output var  logic [12:0] reg_addr_o,
  output var  logic [7:0]  reg_wdata_o,
  output var  logic        io_update_o,
  output var  logic        calibrate_o,
  output var  logic        sync_pulse_o,
  output var  logic        upload_busy_o,
  output var  logic        download_busy_o,
  output var  logic        checksum_error_o,
  output var  logic        overflow_o,
  output var  logic [4:0]  pin_latched_condition_o
);

  localparam int AW = $clog2(EE_BYTES);

  // ****************************************
  // parameter check
  // ****************************************
  if (EE_BYTES < 16 || EE_BYTES > 65536 ||
      (1 << AW) != EE_BYTES) begin : g_bad_size
    $error("EE_BYTES must be a power of two from 16 to 65536");
  end

  typedef struct packed {
    loader_state_e state;
    logic [2:0]    phase;
    logic [7:0]    cnt;
    logic [7:0]    sum;
    logic [12:0]   sp_ptr;
    logic [12:0]   tgt;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [31:0]   tags;
    logic [4:0]    cond;
    logic          exec;
    logic          lat_done;
    logic          auto_pend;
    logic          pe_written;
    logic          pe_armed;
    logic          sync_sent;
    logic          rd;
    logic          wr;
    logic [12:0]   addr;
    logic [7:0]    wdata;
    logic          ioup;
    logic          cal;
    logic          syncp;
    logic          upbusy;
    logic          dnbusy;
    logic          cserr;
    logic          ovf;
    logic [4:0]    pin_lat;
  } loader_s;

  loader_s       s_q;
  loader_s       s_d;
  logic          ee_we;
  logic [7:0]    ee_wdata;
  logic [7:0]    ee_rdata;
  logic [3:0]    pin_raw;
  logic [4:0]    pin_id;
  logic [7:0]    b;
  logic [7:0]    tag_off;
  logic          is_cond;
  logic          is_data;
  logic          exec_now;
  logic          wptr_last;
  logic          rptr_last;

  // ****************************************
  // byte store
  // ****************************************
  eeprom_store #(
    .WIDTH (8),
    .DEPTH (EE_BYTES),
    .AW    (AW)
  ) u_store (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .we_i      (ee_we),
    .waddr_i   (s_q.wptr),
    .wdata_i   (ee_wdata),
    .raddr_i   (s_q.rptr),
    .rdata_o   (ee_rdata)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d       = s_q;
    s_d.rd    = 1'b0;
    s_d.wr    = 1'b0;
    s_d.ioup  = 1'b0;
    s_d.cal   = 1'b0;
    s_d.syncp = 1'b0;
    ee_we     = 1'b0;
    ee_wdata  = reg_rdata_i;
    // tri-level pins to ids 1..8, open-open bypasses
    pin_raw   = 4'(config_select_pin_hi_i) * 4'h3
              + 4'(config_select_pin_lo_i) + 4'h1;
    if (pin_raw == PIN_ID_BYPASS) begin
      pin_id = 5'h00;
    end else if (pin_raw > PIN_ID_BYPASS) begin
      pin_id = 5'(pin_raw - 4'h1);
    end else begin
      pin_id = 5'(pin_raw);
    end
    b         = (s_q.state == ST_DN_USE) ? ee_rdata : reg_rdata_i;
    is_cond   = (b >= OP_NULL_COND) && (b <= OP_COND_LAST);
    is_data   = (b <= OP_DATA_LAST) && (b != OP_CALIBRATE);
    tag_off   = b - OP_NULL_COND;
    exec_now  = (s_q.cond == 5'h00) || (s_q.tags == 32'h0000_0000)
              || s_q.tags[s_q.cond];                          // see RQ16
    wptr_last = (s_q.wptr == {AW{1'b1}});                      // see RQ7
    rptr_last = (s_q.rptr == {AW{1'b1}});

    if (!s_q.lat_done) begin
      s_d.lat_done  = 1'b1;
      s_d.pin_lat   = pin_id;
      s_d.auto_pend = (pin_id != 5'h00);                       // see RQ6
    end

    case (s_q.state)
      ST_IDLE: begin
        if (s_q.lat_done && upload_start_i) begin              // see RQ19
          s_d.state  = ST_UP_FETCH;                            // see RQ4
          s_d.upbusy = 1'b1;
          s_d.phase  = PH_OPCODE;
          s_d.sp_ptr = SCRATCH_BASE;
          s_d.ovf    = 1'b0;
        end else if (s_q.lat_done &&
                     (download_start_i || s_q.auto_pend)) begin
          s_d.state      = ST_DN_FETCH;                        // see RQ5
          s_d.auto_pend  = 1'b0;
          s_d.dnbusy     = 1'b1;
          s_d.phase      = PH_OPCODE;
          s_d.rptr       = '0;
          s_d.tags       = 32'h0000_0000;
          s_d.cond       = (condition_i != COND_RESET) ?
                           condition_i : s_q.pin_lat;          // see RQ17
          s_d.cserr      = 1'b0;
          s_d.ovf        = 1'b0;
          s_d.pe_written = 1'b0;
          s_d.pe_armed   = 1'b0;
          s_d.sync_sent  = 1'b0;
        end
      end
      ST_UP_FETCH: begin
        if (s_q.phase != PH_DATA && s_q.sp_ptr > SCRATCH_LAST) begin
          s_d.state  = ST_IDLE;
          s_d.upbusy = 1'b0;
          s_d.ovf    = 1'b1;
        end else begin
          s_d.rd    = 1'b1;
          s_d.addr  = (s_q.phase == PH_DATA) ? s_q.tgt : s_q.sp_ptr;
          s_d.state = ST_UP_WAIT;
        end
      end
      ST_UP_WAIT: begin
        s_d.state = ST_UP_STORE;
      end
      ST_UP_STORE: begin
        ee_we     = 1'b1;
        s_d.state = ST_UP_FETCH;
        case (s_q.phase)
          PH_OPCODE: begin
            s_d.sum    = b;
            s_d.sp_ptr = s_q.sp_ptr + 13'h0001;                // see RQ8
            if (is_data) begin
              s_d.cnt   = b;                                   // see RQ10
              s_d.phase = PH_ADDR_HI;
            end else if (b == OP_PAUSE || b == OP_END) begin
              s_d.state  = ST_IDLE;                            // see RQ3
              s_d.upbusy = 1'b0;
            end
          end
          PH_ADDR_HI: begin
            s_d.sum       = s_q.sum + b;
            s_d.tgt[12:8] = b[4:0];
            s_d.sp_ptr    = s_q.sp_ptr + 13'h0001;
            s_d.phase     = PH_ADDR_LO;
          end
          PH_ADDR_LO: begin
            s_d.sum      = s_q.sum + b;
            s_d.tgt[7:0] = b;
            s_d.sp_ptr   = s_q.sp_ptr + 13'h0001;
            s_d.phase    = PH_DATA;
          end
          default: begin
            s_d.sum = s_q.sum + b;
            s_d.tgt = s_q.tgt + 13'h0001;
            s_d.cnt = s_q.cnt - 8'h01;
            if (s_q.cnt == 8'h00) begin
              s_d.state = ST_UP_CSUM;                          // see RQ9
            end
          end
        endcase
        if (wptr_last) begin
          s_d.state  = ST_IDLE;
          s_d.upbusy = 1'b0;
          s_d.ovf    = (s_d.state != ST_IDLE) || s_q.upbusy;
        end else begin
          s_d.wptr = s_q.wptr + 1'b1;                          // see RQ4
        end
      end
      ST_UP_CSUM: begin
        ee_we     = 1'b1;
        ee_wdata  = s_q.sum;                                   // see RQ9
        s_d.phase = PH_OPCODE;
        s_d.state = ST_UP_FETCH;
        if (wptr_last) begin
          s_d.state  = ST_IDLE;
          s_d.upbusy = 1'b0;
          s_d.ovf    = 1'b1;
        end else begin
          s_d.wptr = s_q.wptr + 1'b1;
        end
      end
      ST_DN_FETCH: begin
        s_d.state = ST_DN_USE;
      end
      ST_DN_USE: begin
        s_d.state = ST_DN_FETCH;
        case (s_q.phase)
          PH_OPCODE: begin
            s_d.sum = b;
            if (is_cond) begin
              if (b == OP_NULL_COND) begin
                s_d.tags = 32'h0000_0000;                      // see RQ18
              end else begin
                s_d.tags[tag_off[4:0]] = 1'b1;                 // see RQ1
              end
            end else if (b == OP_END) begin
              s_d.state  = ST_IDLE;                            // see RQ3
              s_d.dnbusy = 1'b0;                               // see RQ19
            end else if (is_data) begin
              s_d.cnt   = b;                                   // see RQ10
              s_d.exec  = exec_now;
              s_d.phase = PH_ADDR_HI;
            end else if (exec_now && b == OP_IO_UPDATE) begin
              s_d.ioup     = 1'b1;                             // see RQ11
              s_d.pe_armed = s_q.pe_written;
            end else if (exec_now && b == OP_CALIBRATE) begin
              s_d.cal = 1'b1;
            end
          end
          PH_ADDR_HI: begin
            s_d.sum       = s_q.sum + b;
            s_d.tgt[12:8] = b[4:0];
            s_d.phase     = PH_ADDR_LO;
          end
          PH_ADDR_LO: begin
            s_d.sum      = s_q.sum + b;
            s_d.tgt[7:0] = b;
            s_d.phase    = PH_DATA;
          end
          PH_DATA: begin
            s_d.sum = s_q.sum + b;
            s_d.tgt = s_q.tgt + 13'h0001;
            s_d.cnt = s_q.cnt - 8'h01;
            if (s_q.cnt == 8'h00) begin
              s_d.phase = PH_CSUM;
            end
            if (s_q.exec) begin
              s_d.wr    = 1'b1;
              s_d.addr  = s_q.tgt;
              s_d.wdata = b;
              if (s_q.tgt == REG_IO_UPDATE && b == IO_UPDATE_VAL) begin
                s_d.ioup     = 1'b1;                           // see RQ14
                s_d.pe_armed = s_q.pe_written;
              end
              if (s_q.tgt == REG_PIN_ENABLE && b == PIN_ENABLE_VAL) begin
                s_d.pe_written = 1'b1;                         // see RQ12
              end
              if (s_q.tgt >= REG_PIN_FUNC_FIRST &&
                  s_q.tgt <= REG_PIN_FUNC_LAST &&
                  !s_q.pe_armed && !s_q.sync_sent) begin
                s_d.syncp     = 1'b1;                          // see RQ13
                s_d.sync_sent = 1'b1;
              end
            end
          end
          default: begin
            s_d.phase = PH_OPCODE;
            if (b != s_q.sum) begin
              s_d.cserr  = 1'b1;
              s_d.state  = ST_IDLE;
              s_d.dnbusy = 1'b0;
            end
          end
        endcase
        if (rptr_last && s_d.state != ST_IDLE) begin
          s_d.state  = ST_IDLE;
          s_d.dnbusy = 1'b0;
          s_d.ovf    = 1'b1;
        end else begin
          s_d.rptr = s_q.rptr + 1'b1;
        end
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q       <= '0;
      s_q.state <= ST_IDLE;
      s_q.cond  <= COND_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rd_o                = s_q.rd;
  assign reg_wr_o                = s_q.wr;
  assign reg_addr_o              = s_q.addr;
  assign reg_wdata_o             = s_q.wdata;
  assign io_update_o             = s_q.ioup;
  assign calibrate_o             = s_q.cal;
  assign sync_pulse_o            = s_q.syncp;
  assign upload_busy_o           = s_q.upbusy;
  assign download_busy_o         = s_q.dnbusy;
  assign checksum_error_o        = s_q.cserr;
  assign overflow_o              = s_q.ovf;
  assign pin_latched_condition_o = s_q.pin_lat;

endmodule // eeprom_setup_loader

`default_nettype wire

/* File: design/eeprom_setup_pkg.sv */
/*
  constants, opcodes and state codes of the eeprom setup loader.
  assumes a byte-wide register map with 13-bit register addresses.
*/
`default_nettype none

package eeprom_setup_pkg;

  // ****************************************
  // instruction bytes
  // ****************************************
  localparam logic [7:0] OP_DATA_LAST  = 8'h7F;
  localparam logic [7:0] OP_CALIBRATE  = 8'h0A;
  localparam logic [7:0] OP_IO_UPDATE  = 8'h80;
  localparam logic [7:0] OP_NULL_COND  = 8'hB0;
  localparam logic [7:0] OP_COND_LAST  = 8'hCF;
  localparam logic [7:0] OP_PAUSE      = 8'hFE;
  localparam logic [7:0] OP_END        = 8'hFF;

  // ****************************************
  // register map addresses and values
  // ****************************************
  localparam logic [12:0] SCRATCH_BASE       = 13'h0E10;
  localparam logic [12:0] SCRATCH_LAST       = 13'h0E3F;
  localparam logic [12:0] REG_IO_UPDATE      = 13'h0005;
  localparam logic [12:0] REG_PIN_ENABLE     = 13'h0200;
  localparam logic [12:0] REG_PIN_FUNC_FIRST = 13'h0201;
  localparam logic [12:0] REG_PIN_FUNC_LAST  = 13'h0208;
  localparam logic [7:0]  IO_UPDATE_VAL      = 8'h01;
  localparam logic [7:0]  PIN_ENABLE_VAL     = 8'h01;

  // ****************************************
  // sizes, pin levels and reset values
  // ****************************************
  localparam int          EE_BYTES_DEFAULT = 2048;
  localparam logic [1:0]  PIN_LOW          = 2'h0;
  localparam logic [1:0]  PIN_OPEN         = 2'h1;
  localparam logic [1:0]  PIN_HIGH         = 2'h2;
  localparam logic [4:0]  COND_RESET       = 5'h00;
  localparam logic [3:0]  PIN_ID_BYPASS    = 4'h5;

  // ****************************************
  // instruction parse phases
  // ****************************************
  localparam logic [2:0] PH_OPCODE  = 3'h0;
  localparam logic [2:0] PH_ADDR_HI = 3'h1;
  localparam logic [2:0] PH_ADDR_LO = 3'h2;
  localparam logic [2:0] PH_DATA    = 3'h3;
  localparam logic [2:0] PH_CSUM    = 3'h4;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_UP_FETCH = 3'h1,
    ST_UP_WAIT  = 3'h2,
    ST_UP_STORE = 3'h3,
    ST_UP_CSUM  = 3'h4,
    ST_DN_FETCH = 3'h5,
    ST_DN_USE   = 3'h6
  } loader_state_e;

endpackage

`default_nettype wire

/* File: design/eeprom_store.sv */
/*
  byte store of the setup loader: one write port, one read port.
  read data come out of a register one cycle after the address.
*/
`timescale 1ns/1ps
`default_nettype none

module eeprom_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2048,
  parameter int AW    = 11
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_n_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [AW-1:0]    raddr_i,
  output var  logic [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // ****************************************
  // parameter check
  // ****************************************
  if (WIDTH < 1 || DEPTH < 2 || DEPTH > (1 << AW)) begin : g_bad_size
    $error("store depth does not fit its address width");
  end

  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end

endmodule // eeprom_store

`default_nettype wire

/* File: tb/eeprom_setup_checker.sv */
/*
  port assertions of the setup loader.
  assumes it is bound to eeprom_setup_loader.
*/
`timescale 1ns/1ps
`default_nettype none

module eeprom_setup_checker
  import eeprom_setup_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  input wire logic        upload_start_i,
  input wire logic        download_start_i,
  input wire logic [1:0]  config_select_pin_lo_i,
  input wire logic [1:0]  config_select_pin_hi_i,
  input wire logic        reg_rd_o,
  input wire logic        reg_wr_o,
  input wire logic [12:0] reg_addr_o,
  input wire logic [7:0]  reg_wdata_o,
  input wire logic        io_update_o,
  input wire logic        sync_pulse_o,
  input wire logic        upload_busy_o,
  input wire logic        download_busy_o,
  input wire logic [4:0]  pin_latched_condition_o
);
  // ********
  // edges since reset and pin decode
  // ********
  logic [1:0] edges_q;
  logic [3:0] idx;
  logic [4:0] pin_id;
  logic       idle;

  assign idx = 4'(config_select_pin_hi_i) * 4'h3
             + 4'(config_select_pin_lo_i);
  assign pin_id = (idx == 4'h4) ? 5'h00
                : (idx < 4'h4) ? 5'(idx + 4'h1) : 5'(idx);
  assign idle = !upload_busy_o && !download_busy_o && edges_q == 2'h3;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      edges_q <= 2'h0;
    end else if (edges_q != 2'h3) begin
      edges_q <= edges_q + 2'h1;
    end
  end

  // ********
  // assertions
  // ********
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  a_pin_decode: assert property (
    edges_q == 2'h1 |-> pin_latched_condition_o == pin_id)
    else $error("pin condition decoded wrongly");
  a_pin_hold: assert property (
    edges_q == 2'h2 || edges_q == 2'h3 |-> $stable(pin_latched_condition_o))
    else $error("pin condition changed after latch");
  a_auto_start: assert property (
    edges_q == 2'h1 && pin_id != 5'h00 |=> download_busy_o)
    else $error("automatic download missing");
  a_upload_take: assert property (
    idle && upload_start_i |=> upload_busy_o && !download_busy_o)
    else $error("upload start not taken");
  a_download_take: assert property (
    idle && download_start_i && !upload_start_i |=> download_busy_o)
    else $error("download start not taken");
  a_ops_exclusive: assert property (
    !(upload_busy_o && download_busy_o))
    else $error("upload and download both busy");
  a_read_spacing: assert property (
    reg_rd_o |-> upload_busy_o ##1 !reg_rd_o [*2])
    else $error("scratch read out of place");
  a_write_spacing: assert property (
    reg_wr_o |-> download_busy_o && !reg_rd_o ##1 !reg_wr_o)
    else $error("register write out of place");
  a_sync_on_pin: assert property (
    sync_pulse_o |-> reg_wr_o && reg_addr_o >= REG_PIN_FUNC_FIRST
      && reg_addr_o <= REG_PIN_FUNC_LAST)
    else $error("sync pulse without pin function write");
  a_io_on_write: assert property (
    reg_wr_o && reg_addr_o == REG_IO_UPDATE && reg_wdata_o == IO_UPDATE_VAL
      |-> ##[0:2] io_update_o)
    else $error("io update write gave no update");
endmodule // eeprom_setup_checker

bind eeprom_setup_loader eeprom_setup_checker u_checker (
  .clk_sys_i, .reset_n_i, .upload_start_i, .download_start_i,
  .config_select_pin_lo_i, .config_select_pin_hi_i, .reg_rd_o, .reg_wr_o,
  .reg_addr_o, .reg_wdata_o, .io_update_o, .sync_pulse_o, .upload_busy_o,
  .download_busy_o, .pin_latched_condition_o
);

`default_nettype wire

/* File: tb/testbench.sv */
/*
  self-checking bench of the setup loader with a register map model.
  assumes the package, store and loader are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench
  import eeprom_setup_pkg::*;
;
  // ********
  // signals and register map
  // ********
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        up_go = 1'b0;
  logic        dn_go = 1'b0;
  logic [4:0]  cond = 5'h00;
  logic [1:0]  pin_lo = PIN_OPEN;
  logic [1:0]  pin_hi = PIN_OPEN;
  logic [7:0]  rdata = 8'h00;
  logic        rd, wr, io_upd, calib, sync, up_busy, dn_busy, cs_err, ovf;
  logic [12:0] addr;
  logic [7:0]  wdata, r0, r1, r2;
  logic [4:0]  pin_cond, id, e;
  logic [7:0]  regmap [0:8191];
  logic [21:0] notes [$];
  int          fail_count = 0, samples_checked = 0, n_io, n_cal;
  int          seed = 56458;

  always #10 clk = ~clk;

  eeprom_setup_loader #(.EE_BYTES(64)) dut (
    .clk_sys_i(clk), .reset_n_i(reset_n), .upload_start_i(up_go),
    .download_start_i(dn_go), .condition_i(cond),
    .config_select_pin_lo_i(pin_lo), .config_select_pin_hi_i(pin_hi),
    .reg_rdata_i(rdata), .reg_rd_o(rd), .reg_wr_o(wr), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .io_update_o(io_upd), .calibrate_o(calib),
    .sync_pulse_o(sync), .upload_busy_o(up_busy), .download_busy_o(dn_busy),
    .checksum_error_o(cs_err), .overflow_o(ovf),
    .pin_latched_condition_o(pin_cond)
  );

  // read data valid one cycle, then scrambled
  always @(posedge clk) begin
    rdata <= rd ? regmap[addr] : ~rdata;
    if (wr) regmap[addr] <= wdata;
    if (io_upd) n_io++;
    if (calib) n_cal++;
    if (wr && notes.size() == 0) check("extra write", 22'h1, 22'h0);
    else if (wr) check("write", {sync, addr, wdata}, notes.pop_front());
  end

  // ********
  // tasks
  // ********
  task automatic check(input string what, input logic [21:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while ((up_busy || dn_busy) && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) begin
      fail_count++;
      stop_test();
    end
  endtask

  task automatic load(input logic [7:0] b [$]);
    foreach (b[i]) regmap[SCRATCH_BASE + 13'(i)] = b[i];
  endtask

  task automatic run_op(input logic up, input logic [4:0] c);
    @(posedge clk);
    up_go <= up;
    dn_go <= !up;
    cond <= c;
    @(posedge clk);
    up_go <= 1'b0;
    dn_go <= 1'b0;
    @(negedge clk);
    check("busy", 22'({up_busy, dn_busy}), 22'({up, !up}));
    wait_idle();
  endtask

  task automatic expect_set(input logic [4:0] x);
    @(negedge clk);
    n_io = 0;
    n_cal = 0;
    if (x == 5'h00 || x == 5'h01) notes.push_back({1'b0, 13'h0110, r0});
    if (x == 5'h00 || x == 5'h03) begin
      notes.push_back({1'b0, 13'h0120, r1});
      notes.push_back({1'b0, 13'h0121, r2});
      notes.push_back({1'b1, 13'h0201, 8'h01});
      notes.push_back({1'b0, REG_IO_UPDATE, IO_UPDATE_VAL});
    end
  endtask

  task automatic verify(input logic [4:0] x);
    logic s;
    s = (x == 5'h00 || x == 5'h03);
    repeat (2) @(negedge clk);
    check("writes left", 22'(notes.size()), 22'h0);
    check("io calib", 22'({n_io[3:0], n_cal[3:0]}), 22'({s, 1'b0, 3'h0, s}));
    check("flags", 22'({cs_err, ovf}), 22'h0);
    notes.delete();
  endtask

  task automatic dl(input logic [4:0] c, input logic [4:0] x);
    expect_set(x);
    run_op(1'b0, c);
    verify(x);
    $display("test download %0d done", c);
  endtask

  // ********
  // sequence
  // ********
  initial begin
    for (int i = 0; i < 8192; i++) regmap[i] = 8'h00;
    r0 = 8'($random(seed));
    r1 = 8'($random(seed));
    r2 = 8'($random(seed));
    regmap[13'h0110] = r0;
    regmap[13'h0120] = r1;
    regmap[13'h0121] = r2;
    regmap[13'h0201] = 8'h01;
    regmap[REG_IO_UPDATE] = IO_UPDATE_VAL;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(negedge clk);
    check("power-up", 22'({pin_cond, dn_busy}), 22'h0);
    load('{8'hB1, 8'h00, 8'h01, 8'h10, OP_PAUSE});
    run_op(1'b1, 5'h00);
    load('{OP_NULL_COND, 8'hB3, 8'h01, 8'h01, 8'h20, OP_CALIBRATE,
           OP_IO_UPDATE, 8'h00, 8'h02, 8'h01, 8'h00, 8'h00, 8'h05,
           OP_END});
    run_op(1'b1, 5'h00);
    $display("test uploads done");
    dl(5'h01, 5'h01);
    dl(5'h03, 5'h03);
    dl(5'h00, 5'h00);
    dl(5'h02, 5'h02);
    for (int p = 0; p < 9; p++) begin
      id = (p == 4) ? 5'h00 : (p < 4) ? 5'(p + 1) : 5'(p);
      e = (id == 5'h00) ? 5'h1F : id;
      expect_set(e);
      @(posedge clk);
      reset_n <= 1'b0;
      cond <= 5'h00;
      pin_hi <= 2'(p / 3);
      pin_lo <= 2'(p % 3);
      @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(negedge clk);
      check("pins", 22'({pin_cond, dn_busy}), 22'({id, id != 5'h00}));
      wait_idle();
      verify(e);
    end
    $display("test pin conditions done");
    dl(5'h00, 5'h08);
    dl(5'h01, 5'h01);
    // default entries up to 0x0E16, inserted steps from 0x0E17
    load('{OP_NULL_COND, 8'h01, 8'h01, 8'h20, OP_CALIBRATE, OP_NULL_COND,
           OP_NULL_COND, 8'h00, 8'h02, 8'h00, OP_IO_UPDATE, 8'h10, 8'h02,
           8'h01, OP_END});
    regmap[REG_PIN_ENABLE] = PIN_ENABLE_VAL;
    run_op(1'b1, 5'h00);
    expect_set(5'h1F);
    notes.push_back({1'b0, 13'h0120, r1});
    notes.push_back({1'b0, 13'h0121, r2});
    notes.push_back({1'b0, REG_PIN_ENABLE, PIN_ENABLE_VAL});
    for (int i = 0; i < 17; i++) begin
      notes.push_back({1'b0, REG_PIN_FUNC_FIRST + 13'(i), 8'(i == 0)});
    end
    run_op(1'b0, 5'h00);
    repeat (2) @(negedge clk);
    check("armed writes left", 22'(notes.size()), 22'h0);
    check("armed io calib", 22'({n_io[3:0], n_cal[3:0]}), 22'h11);
    check("armed flags", 22'({cs_err, ovf}), 22'h0);
    $display("test pin sync layout done");
    for (int i = 0; i < 48; i++) regmap[SCRATCH_BASE + 13'(i)] = OP_IO_UPDATE;
    run_op(1'b1, 5'h00);
    check("overflow", 22'({ovf, up_busy}), 22'h2);
    $display("test overflow done");
    @(posedge clk);
    reset_n <= 1'b0;
    pin_hi <= PIN_OPEN;
    pin_lo <= PIN_OPEN;
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(negedge clk);
    run_op(1'b1, 5'h00);
    check("scratch end", 22'({ovf, up_busy}), 22'h2);
    n_io = 0;
    run_op(1'b0, 5'h00);
    @(negedge clk);
    check("store end", 22'({ovf, dn_busy, n_io[7:0]}), 22'h240);
    $display("test store end done");
    stop_test();
  end
endmodule // testbench

`default_nettype wire
